//--- hdl/ita_top.v
`timescale 1ns/10ps
`include "ita_consts.vh"
// Indirect table access window of the switch core.
module ita_top (
  input  wire        SYS_CLK,
  input  wire        RESETN,
  input  wire        CE,
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_WDATA,
  output reg  [7:0]  REG_RDATA,
  output reg         REG_RVALID,
  output wire        REG_READY,
  output reg         TBL_REQ,
  output reg         TBL_WRITE,
  output reg  [2:0]  TBL_GROUP,
  output reg  [2:0]  TBL_PORT,
  output reg  [11:0] TBL_INDEX,
  output reg  [63:0] TBL_WDATA,
  input  wire        TBL_ACK,
  input  wire [63:0] TBL_RDATA,
  output reg         ACCESS_ERROR
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ  = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [7:0]  ctrl;
  reg  [7:0]  addr_lo;
  reg  [7:0]  byte_data;
  reg  [7:0]  rd_sel_addr;
  reg         rd_pend;
  reg  [7:0]  direct_q;
  reg         dec_ok;
  reg  [2:0]  dec_group;
  reg  [2:0]  dec_port;
  reg  [11:0] dec_index;
  wire [2:0]  acc_class = ctrl[`ITA_CLASS_MSB:`ITA_CLASS_LSB];
  wire [1:0]  tsel      = ctrl[`ITA_TSEL_MSB:`ITA_TSEL_LSB];
  wire [3:0]  nib       = ctrl[3:0];
  wire        is_read   = ctrl[`ITA_READ_BIT];
  wire        busy      = (state != ST_IDLE);
  wire        wr_ok     = REG_WR & ~busy & CE;
  wire        rd_ok     = REG_RD & ~busy & CE;
  wire        in_data   = (REG_ADDR >= `ITA_OFS_DATA_HI) && (REG_ADDR <= `ITA_OFS_DATA_LO);
  wire [2:0]  data_idx  = REG_ADDR[2:0] - 3'h1;
  wire        trigger   = wr_ok && (REG_ADDR == `ITA_OFS_ADDR_LO);
  wire [7:0]  dbuf_rd;
  wire [63:0] entry;
  wire        load_we   = (state == ST_WAIT) && TBL_ACK && !TBL_WRITE && (TBL_GROUP <= `ITA_GRP_MIB);
  wire [11:0] tbl_addr  = {2'h0, ctrl[1:0], addr_lo};
  wire [11:0] port_addr = {nib, addr_lo};

  // The host must wait for REG_READY, so no data-register access overtakes a read.
  assign REG_READY = ~busy;

  ita_data_bytes u_data (
    .clk        (SYS_CLK),
    .resetn     (RESETN),
    .ce         (CE),
    .byte_we    (wr_ok & in_data),
    .byte_idx   (data_idx),
    .byte_wdata (REG_WDATA),
    .load_we    (load_we),
    .load_data  (TBL_RDATA),
    .rd_idx     (data_idx),
    .rd_data    (dbuf_rd),
    .entry      (entry)
  );

  // Decodes the class, table choice and index into a target group and port.
  always @* begin
    dec_ok    = 1'b0;
    dec_group = `ITA_GRP_STATIC;
    dec_port  = 3'h0;
    dec_index = tbl_addr;
    case (acc_class)
      `ITA_CLASS_TABLE: begin
        case (tsel)
          `ITA_TSEL_STATIC: begin
            dec_group = `ITA_GRP_STATIC;
            dec_ok    = (tbl_addr <= `ITA_STATIC_LAST);
          end
          `ITA_TSEL_VLAN: begin
            dec_group = `ITA_GRP_VLAN;
            dec_ok    = (tbl_addr <= `ITA_VLAN_LAST);
          end
          `ITA_TSEL_DYN: begin
            dec_group = `ITA_GRP_DYN;
            dec_ok    = (tbl_addr <= `ITA_DYN_LAST);
          end
          default: begin
            dec_group = `ITA_GRP_MIB;
            if (tbl_addr <= `ITA_MIB_PORT_LAST) begin
              dec_ok    = 1'b1;
              dec_port  = tbl_addr[7:5] + 3'h1;
              dec_index = {7'h00, tbl_addr[4:0]};
            end else if ((tbl_addr >= `ITA_MIB_TOT_FIRST) && (tbl_addr <= `ITA_MIB_TOT_LAST)) begin
              dec_ok = 1'b1;
            end
          end
        endcase
      end
      `ITA_CLASS_EEE: begin
        dec_group = `ITA_GRP_EEE;
        dec_index = port_addr;
        dec_port  = nib[2:0];
        dec_ok    = (nib != 4'h0) && (nib <= `ITA_PORT_LAST) && (addr_lo <= `ITA_EEE_LAST);
      end
      `ITA_CLASS_ACL: begin
        dec_group = `ITA_GRP_ACL;
        dec_index = port_addr;
        dec_port  = nib[2:0];
        dec_ok    = (nib != 4'h0) && (nib <= `ITA_PORT_LAST) && (addr_lo <= `ITA_ACL_LAST);
      end
      `ITA_CLASS_CFG: begin
        dec_group = `ITA_GRP_CFG;
        dec_index = port_addr;
        dec_port  = nib[2:0];
        dec_ok    = (nib <= `ITA_CFG_PORT_LAST);
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trigger)
          next_state = ST_REQ;
      end
      ST_REQ: begin
        if (!dec_ok)
          next_state = ST_IDLE;
        else
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (TBL_ACK)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state        <= ST_IDLE;
      ctrl         <= `ITA_CTRL_RESET;
      addr_lo      <= `ITA_DATA_RESET;
      byte_data    <= `ITA_DATA_RESET;
      TBL_REQ      <= 1'b0;
      TBL_WRITE    <= 1'b0;
      TBL_GROUP    <= `ITA_GRP_STATIC;
      TBL_PORT     <= 3'h0;
      TBL_INDEX    <= 12'h000;
      TBL_WDATA    <= 64'h0000000000000000;
      ACCESS_ERROR <= 1'b0;
    end else if (CE) begin
      state   <= next_state;
      TBL_REQ <= 1'b0;
      if (wr_ok && (REG_ADDR == `ITA_OFS_CTRL))
        ctrl <= REG_WDATA;
      if (trigger)
        addr_lo <= REG_WDATA;
      if (wr_ok && (REG_ADDR == `ITA_OFS_BYTE_DATA))
        byte_data <= REG_WDATA;
      if (state == ST_REQ) begin
        ACCESS_ERROR <= ~dec_ok;
        if (dec_ok) begin
          TBL_REQ   <= 1'b1;
          TBL_WRITE <= ~is_read;
          TBL_GROUP <= dec_group;
          TBL_PORT  <= dec_port;
          TBL_INDEX <= dec_index;
          // Table class moves whole entries; the other classes move one byte.
          if (acc_class == `ITA_CLASS_TABLE)
            TBL_WDATA <= entry;
          else
            TBL_WDATA <= {56'h00000000000000, byte_data};
        end
      end
      if ((state == ST_WAIT) && TBL_ACK && !TBL_WRITE && (TBL_GROUP > `ITA_GRP_MIB))
        byte_data <= TBL_RDATA[7:0];
    end
  end

  // Register reads answer two cycles after the strobe, from flip-flops.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_pend     <= 1'b0;
      rd_sel_addr <= 8'h00;
      direct_q    <= 8'h00;
      REG_RDATA   <= 8'h00;
      REG_RVALID  <= 1'b0;
    end else if (CE) begin
      rd_pend     <= rd_ok;
      rd_sel_addr <= REG_ADDR;
      case (REG_ADDR)
        `ITA_OFS_CTRL:      direct_q <= ctrl;
        `ITA_OFS_ADDR_LO:   direct_q <= addr_lo;
        `ITA_OFS_BYTE_DATA: direct_q <= byte_data;
        default:            direct_q <= 8'h00;
      endcase
      REG_RVALID <= rd_pend;
      if (rd_pend) begin
        if ((rd_sel_addr >= `ITA_OFS_DATA_HI) && (rd_sel_addr <= `ITA_OFS_DATA_LO))
          REG_RDATA <= dbuf_rd;
        else
          REG_RDATA <= direct_q;
      end
    end
  end
endmodule

//--- hdl/ita_consts.vh
// Contract
// - Control register bits 7-5 pick the access class of an indirect access.
// - Class 000 uses control bits 3-2 to pick static, VLAN, dynamic or counter table.
// - Table choice 00 maps indices 0x000-0x01F onto 32 static entries.
// - Table choice 01 maps indices up to 0x1FF onto VLAN buckets of four.
// - Table choice 10 reaches the 1024-entry learned address table.
// - Table choice 11 gives each of five ports 32 counters, 0x020 apart.
// - Total-byte and dropped counters sit at 0x100 upward, above port blocks.
// - Other classes take address bits 11-8 from control bits 3-0.
// - Class 001 reaches six 16-bit energy-saving words per port via byte data; the code moves only bits 7-0 of each word.
// - Class 010 reaches sixteen filter entries per port, two addresses each.
// - Class 100 reaches configuration space: nibble 0 global, 1-4 ports.
// - Entry data travels in eight byte registers, most significant byte first.
`ifndef ITA_CONSTS_VH
`define ITA_CONSTS_VH
`define ITA_OFS_CTRL      8'h6e
`define ITA_OFS_ADDR_LO   8'h6f
`define ITA_OFS_DATA_HI   8'h71
`define ITA_OFS_DATA_LO   8'h78
`define ITA_OFS_BYTE_DATA 8'ha0
`define ITA_CTRL_RESET    8'h00
`define ITA_CLASS_MSB     7
`define ITA_CLASS_LSB     5
`define ITA_READ_BIT      4
`define ITA_TSEL_MSB      3
`define ITA_TSEL_LSB      2
`define ITA_CLASS_TABLE   3'h0
`define ITA_CLASS_EEE     3'h1
`define ITA_CLASS_ACL     3'h2
`define ITA_CLASS_CFG     3'h4
`define ITA_TSEL_STATIC   2'h0
`define ITA_TSEL_VLAN     2'h1
`define ITA_TSEL_DYN      2'h2
`define ITA_TSEL_MIB      2'h3
`define ITA_GRP_STATIC    3'h0
`define ITA_GRP_VLAN      3'h1
`define ITA_GRP_DYN       3'h2
`define ITA_GRP_MIB       3'h3
`define ITA_GRP_EEE       3'h4
`define ITA_GRP_ACL       3'h5
`define ITA_GRP_CFG       3'h6
`define ITA_STATIC_LAST   12'h01f
`define ITA_VLAN_LAST     12'h1ff
`define ITA_DYN_LAST      12'h3ff
`define ITA_MIB_PORT_LAST 12'h09f
`define ITA_MIB_TOT_FIRST 12'h100
`define ITA_MIB_TOT_LAST  12'h113
`define ITA_EEE_LAST      8'h05
`define ITA_ACL_LAST      8'h1f
`define ITA_PORT_LAST     4'h5
`define ITA_CFG_PORT_LAST 4'h4
`define ITA_DATA_RESET    8'h00
`endif

//--- hdl/ita_data_bytes.v
`timescale 1ns/10ps
`include "ita_consts.vh"
// Eight-byte entry buffer; byte 0 holds bits 63:56. Read data is registered.
module ita_data_bytes (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        byte_we,
  input  wire [2:0]  byte_idx,
  input  wire [7:0]  byte_wdata,
  input  wire        load_we,
  input  wire [63:0] load_data,
  input  wire [2:0]  rd_idx,
  output reg  [7:0]  rd_data,
  output wire [63:0] entry
);
  reg [7:0] mem [0:7];
  integer   i;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_entry
      assign entry[63-8*g -: 8] = mem[g];
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1)
        mem[i] <= `ITA_DATA_RESET;
      rd_data <= `ITA_DATA_RESET;
    end else if (ce) begin
      if (load_we) begin
        for (i = 0; i < 8; i = i + 1)
          mem[i] <= load_data[63-8*i -: 8];
      end else if (byte_we) begin
        mem[byte_idx] <= byte_wdata;
      end
      rd_data <= mem[rd_idx];
    end
  end
endmodule

//--- verification/ita_top_sva.sv
`timescale 1ns/10ps
module ita_top_sva (
  input wire        SYS_CLK,
  input wire        RESETN,
  input wire        CE,
  input wire [7:0]  REG_ADDR,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [7:0]  REG_WDATA,
  input wire        REG_RVALID,
  input wire        REG_READY,
  input wire        TBL_REQ,
  input wire        TBL_WRITE,
  input wire [2:0]  TBL_GROUP,
  input wire [2:0]  TBL_PORT,
  input wire [11:0] TBL_INDEX,
  input wire        TBL_ACK,
  input wire        ACCESS_ERROR
);
  reg  [7:0] ctrl;
  wire       wr_ok = CE && REG_WR && REG_READY;
  wire       trig  = wr_ok && REG_ADDR == 8'h6f;
  wire [2:0] cls   = ctrl[7:5];
  wire [2:0] grp   = (cls == 3'h0) ? {1'b0, ctrl[3:2]} : (cls == 3'h1) ? 3'h4 : (cls == 3'h2) ? 3'h5 : 3'h6;
  // Shadow of the control register, so the decode can be predicted at the request.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= 8'h00;
    end else if (wr_ok && REG_ADDR == 8'h6e) begin
      ctrl <= REG_WDATA;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  chk_read_latency: assert property (CE && REG_RD && REG_READY |-> ##2 REG_RVALID)
    else $error("read answer not on time");
  chk_trig_busy: assert property (trig |=> !REG_READY)
    else $error("trigger did not make the window busy");
  chk_trig_outcome: assert property (trig |-> ##2 (TBL_REQ ^ ACCESS_ERROR))
    else $error("trigger gave neither request nor error");
  chk_group_map: assert property (TBL_REQ |-> TBL_GROUP == grp)
    else $error("wrong table group");
  chk_static_range: assert property (TBL_REQ && TBL_GROUP == 3'h0 |-> TBL_INDEX <= 12'h01f)
    else $error("static index out of range");
  chk_dyn_range: assert property (TBL_REQ && TBL_GROUP == 3'h2 |-> TBL_INDEX <= 12'h3ff)
    else $error("learned table index out of range");
  chk_mib_port: assert property (TBL_REQ && TBL_GROUP == 3'h3 && TBL_PORT != 3'h0
    |-> TBL_PORT <= 3'h5 && TBL_INDEX <= 12'h01f)
    else $error("counter port block wrong");
  chk_mib_total: assert property (TBL_REQ && TBL_GROUP == 3'h3 && TBL_PORT == 3'h0
    |-> TBL_INDEX inside {[12'h100:12'h113]})
    else $error("total counter index wrong");
  chk_high_nibble: assert property (TBL_REQ && TBL_GROUP >= 3'h4 |-> TBL_INDEX[11:8] == ctrl[3:0])
    else $error("upper address nibble wrong");
  chk_write_flag: assert property (TBL_REQ |-> TBL_WRITE == !ctrl[4])
    else $error("read or write direction wrong");
  chk_read_done: assert property (TBL_ACK |=> REG_READY)
    else $error("window still busy after table answer");
  cover property (trig ##2 ACCESS_ERROR);
  cover property (TBL_REQ && TBL_WRITE);
  cover property (TBL_ACK ##1 REG_RD);
endmodule
bind ita_top ita_top_sva u_sva (.*);

//--- verification/ita_tbl_model.sv
`timescale 1ns/10ps
module ita_tbl_model (
  input  wire        clk,
  input  wire        resetn,
  input  wire        req,
  input  wire [11:0] index,
  input  wire [3:0]  delay,
  output reg         ack,
  output reg  [63:0] rdata
);
  reg [4:0] cnt;
  // Answers each request once after the chosen delay; data scrambles between answers.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 5'h00;
      ack <= 1'b0;
      rdata <= 64'h0;
    end else begin
      ack <= (cnt == 5'h01);
      rdata <= (cnt == 5'h01) ? ({8{index[7:0]}} ^ 64'h0123456789abcdef) : ~rdata;
      if (req) begin
        cnt <= {1'b0, delay} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

//--- verification/indirect_table_access_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module indirect_table_access_tb;
  reg         SYS_CLK = 1'b0;
  reg         RESETN = 1'b0;
  reg         CE = 1'b1;
  reg  [7:0]  REG_ADDR = 8'h00;
  reg         REG_WR = 1'b0;
  reg         REG_RD = 1'b0;
  reg  [7:0]  REG_WDATA = 8'h00;
  reg  [3:0]  delay = 4'h0;
  wire [7:0]  REG_RDATA;
  wire        REG_RVALID, REG_READY, TBL_REQ, TBL_WRITE, TBL_ACK, ACCESS_ERROR;
  wire [2:0]  TBL_GROUP, TBL_PORT;
  wire [11:0] TBL_INDEX;
  wire [63:0] TBL_WDATA, TBL_RDATA;
  integer     err_total = 0, cmp_count = 0, cyc = 0, i, n;
  reg         seen = 1'b0;
  reg  [63:0] exp;
  reg  [39:0] rows [0:17];
  always #50 SYS_CLK = ~SYS_CLK;
  ita_top u_ita_top (.*);
  ita_tbl_model u_ita_tbl_model (.clk(SYS_CLK), .resetn(RESETN), .req(TBL_REQ), .index(TBL_INDEX),
    .delay(delay), .ack(TBL_ACK), .rdata(TBL_RDATA));
  task wrap_up;
    begin
      if (err_total == 0 && cmp_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge SYS_CLK);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge SYS_CLK);
      REG_WR = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge SYS_CLK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge SYS_CLK);
      REG_RD = 1'b0;
      @(negedge SYS_CLK);
      `CHK(REG_RVALID, 1'b1)
      `CHK(REG_RDATA, e)
    end
  endtask
  task trig(input [7:0] c, input [7:0] lo);
    begin
      wr(8'h6e, c);
      seen = 1'b0;
      wr(8'h6f, lo);
      repeat (3) @(negedge SYS_CLK);
      for (n = 0; n < 40 && REG_READY !== 1'b1; n++) @(negedge SYS_CLK);
      `CHK(REG_READY, 1'b1)
    end
  endtask
  always @(posedge SYS_CLK) begin
    if (TBL_REQ === 1'b1) seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    rows = '{40'h10_01_0_0_0_001, 40'h10_20_1_0_0_000, 40'h15_ff_0_1_0_1ff, 40'h1b_ff_0_2_0_3ff,
      40'h1c_00_0_3_1_000, 40'h1c_9f_0_3_5_01f, 40'h1c_a0_1_0_0_000, 40'h1d_13_0_3_0_113,
      40'h1d_14_1_0_0_000, 40'h33_05_0_4_3_305, 40'h33_06_1_0_0_000, 40'h55_1f_0_5_5_51f,
      40'h50_00_1_0_0_000, 40'h90_00_0_6_0_000, 40'h94_7f_0_6_4_47f, 40'h95_00_1_0_0_000,
      40'h70_00_1_0_0_000, 40'hb0_00_1_0_0_000};
    repeat (10) @(negedge SYS_CLK);
    RESETN = 1'b1;
    for (i = 0; i < 18; i++) begin
      delay = {2'b00, i[1:0]};
      trig(rows[i][39:32], rows[i][31:24]);
      `CHK(ACCESS_ERROR, rows[i][20])
      `CHK(seen, ~rows[i][20])
      if (!rows[i][20]) begin
        `CHK(TBL_GROUP, rows[i][18:16])
        `CHK(TBL_PORT, rows[i][14:12])
        `CHK(TBL_INDEX, rows[i][11:0])
        `CHK(TBL_WRITE, ~rows[i][36])
      end
    end
    trig(8'h10, 8'h01);
    exp = {8{8'h01}} ^ 64'h0123456789abcdef;
    for (i = 0; i < 8; i++) rd(8'h71 + i[7:0], exp[63 - 8 * i -: 8]);
    trig(8'h33, 8'h05);
    rd(8'ha0, 8'h05 ^ 8'hef);
    for (i = 0; i < 8; i++) wr(8'h71 + i[7:0], 8'h80 + i[7:0]);
    trig(8'h00, 8'h07);
    `CHK(TBL_WDATA, 64'h8081828384858687)
    `CHK(TBL_WRITE, 1'b1)
    wr(8'h6e, 8'h5a);
    CE = 1'b0;
    wr(8'h6e, 8'hff);
    CE = 1'b1;
    rd(8'h6e, 8'h5a);
    wr(8'ha0, 8'h3c);
    rd(8'ha0, 8'h3c);
    rd(8'h50, 8'h00);
    RESETN = 1'b0;
    @(negedge SYS_CLK);
    RESETN = 1'b1;
    rd(8'h6e, 8'h00);
    wrap_up;
  end
endmodule
